// ### lbtd_pkg.sv
// Constants, carrier types and helper functions of the LIN trigger decoder.
package lbtd_pkg;

    // Clock rate and field widths.
    localparam int unsigned CLK_HZ   = 100_000_000;
    localparam int          ADC_W    = 12;
    localparam int          BAUD_W   = 20;
    localparam int          DIV_W    = 27;
    localparam int          CNT_W    = 32;
    localparam int          TS_W     = 32;
    localparam int          SEQ_W    = 16;
    localparam int          MAX_DATA = 8;

    // Frame layout constants.
    localparam int          BREAK_BITS     = 13;
    localparam logic [7:0]  SYNC_BYTE      = 8'h55;
    localparam logic [5:0]  CLASSIC_ID_MIN = 6'h3c;
    localparam logic [3:0]  STOP_BIT       = 4'h9;
    localparam logic [3:0]  LEN_SHORT      = 4'h2;
    localparam logic [3:0]  LEN_MID        = 4'h4;
    localparam logic [3:0]  LEN_LONG       = 4'h8;

    // Predefined bit rates in bit/s, picked by the rate selector.
    localparam logic [BAUD_W-1:0] BAUD_TABLE [8] = '{
        20'h00258, 20'h004b0, 20'h00960, 20'h012c0,
        20'h02580, 20'h028b1, 20'h04b00, 20'h04e20
    };

    // Trigger conditions.
    typedef enum logic [1:0] {
        lbtd_break_mode,
        lbtd_identifier_mode,
        identifier_and_payload_match_mode,
        lbtd_error_mode
    } lbtd_mode_t;

    // Parser states.
    typedef enum logic [2:0] {
        st_idle,
        st_sync,
        st_pid,
        st_data,
        st_csum
    } lbtd_state_t;

    // Static configuration supplied by the control side.
    typedef struct packed {
        lbtd_mode_t        mode;
        logic              serial_sel;
        logic [5:0]        match_id;
        logic [7:0]        first_data_match_value;
        logic              first_data_care;
        logic [7:0]        second_data_match_value;
        logic              second_data_care;
        logic [2:0]        baud_sel;
        logic              custom_en;
        logic [BAUD_W-1:0] custom_baud;
        logic [ADC_W-1:0]  threshold;
    } lbtd_cfg_t;

    // One decoded frame.
    typedef struct packed {
        logic [SEQ_W-1:0]           seq;
        logic [TS_W-1:0]            timestamp;
        logic [7:0]                 pid;
        logic [1:0]                 identifier_parity_bits;
        logic [3:0]                 len;
        logic [MAX_DATA-1:0][7:0]   data;
        logic [7:0]                 checksum;
        logic                       err_parity;
        logic                       err_checksum;
    } lbtd_rec_t;

    // Expected parity pair {P1, P0} of a six-bit identifier.
    function automatic logic [1:0] lbtd_parity(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4]};
    endfunction

    // Payload length implied by the identifier's two top bits.
    function automatic logic [3:0] lbtd_data_len(input logic [5:0] id);
        case (id[5:4])
            2'h2:    return LEN_MID;
            2'h3:    return LEN_LONG;
            default: return LEN_SHORT;
        endcase
    endfunction

    // Eight-bit sum with end-around carry.
    function automatic logic [7:0] lbtd_csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction

endpackage

// ### lbtd_sampler.sv
// Threshold slicer that turns the sampled bus voltage into a logic level.
`timescale 1ns/1ps
module lbtd_sampler import lbtd_pkg::*; (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Sample stream, produced on sys_clk by the converter.
    input  wire logic [ADC_W-1:0] adc_sample,
    input  wire logic [ADC_W-1:0] threshold,
    // Sliced level and its previous value.
    output logic                  line_q,
    output logic                  line_prev_q
);
    logic line_d;

    // A sample strictly above the threshold is one, anything else zero.
    always_comb begin
        line_d = (adc_sample > threshold);
    end

    // The idle bus is recessive, so reset to one.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            line_q      <= 1'b1;
            line_prev_q <= 1'b1;
        end else begin
            line_q      <= line_d;
            line_prev_q <= line_q;
        end
    end

    slice_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        line_q == $past(adc_sample > threshold)) else $error("slice level wrong");

endmodule // lbtd_sampler

// ### lbtd_main.sv
// LIN bus monitor: break detection, frame parsing, trigger and frame records.
`timescale 1ns/1ps
module lbtd_main import lbtd_pkg::*; (
    // Clock and reset.
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    // Bus samples and configuration.
    input  wire logic [ADC_W-1:0] adc_sample,
    input  wire lbtd_cfg_t        cfg,
    // Trigger and decoded frames.
    output logic                  trig_q,
    output logic                  rec_valid_q,
    output lbtd_rec_t             rec_q
);
    logic              line;
    logic              line_prev;
    logic [DIV_W-1:0]  bitc;
    logic [CNT_W-1:0]  brk_cyc;
    logic              tim_busy;

    lbtd_state_t       st_q;
    lbtd_state_t       st_d;
    logic              rx_busy_q;
    logic              rx_busy_d;
    logic [DIV_W-1:0]  cnt_q;
    logic [DIV_W-1:0]  cnt_d;
    logic [3:0]        bitn_q;
    logic [3:0]        bitn_d;
    logic [7:0]        shift_q;
    logic [7:0]        shift_d;
    logic [CNT_W-1:0]  low_cnt_q;
    logic [CNT_W-1:0]  low_cnt_d;
    logic [3:0]        idx_q;
    logic [3:0]        idx_d;
    logic [7:0]        sum_q;
    logic [7:0]        sum_d;
    logic              id_hit_q;
    logic              id_hit_d;
    logic              pair_q;
    logic              pair_d;
    logic              trig_d;
    logic              rec_valid_d;
    lbtd_rec_t         rec_d;
    lbtd_rec_t         wrk_q;
    lbtd_rec_t         wrk_d;
    logic [TS_W-1:0]   time_q;
    logic [TS_W-1:0]   trig_time_q;
    logic [TS_W-1:0]   trig_time_d;
    logic [TS_W-1:0]   frame_t_q;
    logic [TS_W-1:0]   frame_t_d;
    logic [SEQ_W-1:0]  seq_q;
    logic [SEQ_W-1:0]  seq_d;

    logic              rise;
    logic              fall;
    logic              brk_evt;
    logic              byte_done;
    logic              stop_ok;
    logic              err_evt;
    logic              trig_evt;
    logic              d1m;
    logic              d2m;
    logic              hit;

    // Slicer and bit-rate source.
    lbtd_sampler u_sampler (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .adc_sample  (adc_sample),
        .threshold   (cfg.threshold),
        .line_q      (line),
        .line_prev_q (line_prev)
    );

    lbtd_bit_timer u_timer (
        .sys_clk        (sys_clk),
        .nrst           (nrst),
        .baud_sel       (cfg.baud_sel),
        .custom_en      (cfg.custom_en),
        .custom_baud    (cfg.custom_baud),
        .bit_cycles_q   (bitc),
        .break_cycles_q (brk_cyc),
        .busy_q         (tim_busy)
    );

    // Edges of the sliced line.
    assign rise = line & ~line_prev;
    assign fall = ~line & line_prev;

    // Next-state logic for the byte receiver, parser, trigger and records.
    always_comb begin
        st_d        = st_q;
        rx_busy_d   = rx_busy_q;
        cnt_d       = cnt_q;
        bitn_d      = bitn_q;
        shift_d     = shift_q;
        idx_d       = idx_q;
        sum_d       = sum_q;
        id_hit_d    = id_hit_q;
        pair_d      = pair_q;
        wrk_d       = wrk_q;
        rec_d       = rec_q;
        rec_valid_d = 1'b0;
        frame_t_d   = frame_t_q;
        seq_d       = seq_q;
        byte_done   = 1'b0;
        stop_ok     = 1'b0;
        err_evt     = 1'b0;
        trig_evt    = 1'b0;
        hit         = 1'b0;

        // Low time counter saturates so a stuck bus cannot wrap into a false break.
        low_cnt_d = low_cnt_q;
        if (line) begin
            low_cnt_d = '0;
        end else if (low_cnt_q != '1) begin
            low_cnt_d = low_cnt_q + CNT_W'(1);
        end
        brk_evt = rise && !tim_busy && (low_cnt_q >= brk_cyc);

        // Byte receiver: start bit checked mid-bit, then eight bits LSB first, then stop.
        if (rx_busy_q) begin
            if (cnt_q == '0) begin
                cnt_d  = bitc - DIV_W'(1);
                bitn_d = bitn_q + 4'h1;
                if (bitn_q == 4'h0 && line) begin
                    rx_busy_d = 1'b0;
                end else if (bitn_q == STOP_BIT) begin
                    byte_done = 1'b1;
                    stop_ok   = line;
                    rx_busy_d = 1'b0;
                end else if (bitn_q != 4'h0) begin
                    shift_d = {line, shift_q[7:1]};
                end
            end else begin
                cnt_d = cnt_q - DIV_W'(1);
            end
        end else if (fall && st_q != st_idle) begin
            rx_busy_d = 1'b1;
            cnt_d     = bitc >> 1;
            bitn_d    = 4'h0;
        end

        // Data comparison; a don't-care value matches any byte.
        d1m = !cfg.first_data_care || (shift_q == cfg.first_data_match_value);
        d2m = !cfg.second_data_care || (shift_q == cfg.second_data_match_value);

        // Frame parser, advanced once per completed byte.
        if (byte_done) begin
            case (st_q)
                st_sync: begin
                    if (stop_ok && shift_q == SYNC_BYTE) begin
                        st_d = st_pid;
                    end else begin
                        err_evt = 1'b1;
                        st_d    = st_idle;
                    end
                end
                st_pid: begin
                    if (!stop_ok) begin
                        st_d = st_idle;
                    end else begin
                        wrk_d.pid                    = shift_q;
                        wrk_d.identifier_parity_bits = shift_q[7:6];
                        wrk_d.len                    = lbtd_data_len(shift_q[5:0]);
                        wrk_d.err_parity             = (shift_q[7:6] != lbtd_parity(shift_q[5:0]));
                        err_evt  = wrk_d.err_parity;
                        id_hit_d = (shift_q[5:0] == cfg.match_id);
                        trig_evt = (cfg.mode == lbtd_identifier_mode) && id_hit_d;
                        sum_d    = (shift_q[5:0] < CLASSIC_ID_MIN) ? shift_q : 8'h00;
                        idx_d    = 4'h0;
                        pair_d   = 1'b0;
                        st_d     = st_data;
                    end
                end
                st_data: begin
                    if (!stop_ok) begin
                        st_d = st_idle;
                    end else begin
                        wrk_d.data[idx_q[2:0]] = shift_q;
                        sum_d = lbtd_csum_add(sum_q, shift_q);
                        idx_d = idx_q + 4'h1;
                        if (idx_d == wrk_q.len) begin
                            st_d = st_csum;
                        end
                        if (cfg.first_data_care && cfg.second_data_care) begin
                            hit = pair_q && d2m;
                        end else if (cfg.first_data_care) begin
                            hit = d1m;
                        end else begin
                            hit = d2m;
                        end
                        pair_d   = d1m;
                        trig_evt = (cfg.mode == identifier_and_payload_match_mode) && id_hit_q && hit;
                    end
                end
                st_csum: begin
                    wrk_d.checksum     = shift_q;
                    wrk_d.err_checksum = (~sum_q != shift_q);
                    err_evt            = wrk_d.err_checksum || !stop_ok;
                    st_d               = st_idle;
                    rec_valid_d        = 1'b1;
                end
                default: begin
                    st_d = st_idle;
                end
            endcase
        end

        // Break delimiter: restart the parser whatever it was doing.
        if (brk_evt) begin
            st_d      = st_sync;
            rx_busy_d = 1'b0;
            wrk_d     = '0;
            frame_t_d = time_q;
            id_hit_d  = 1'b0;
            trig_evt  = (cfg.mode == lbtd_break_mode);
        end

        if (cfg.mode == lbtd_error_mode && err_evt) begin
            trig_evt = 1'b1;
        end
        // The trigger only leaves the block when serial triggering is chosen.
        trig_d      = trig_evt && cfg.serial_sel;
        trig_time_d = trig_d ? time_q : trig_time_q;

        // Record emission with sequence number and offset to the latest trigger.
        if (rec_valid_d) begin
            rec_d           = wrk_d;
            rec_d.seq       = seq_q;
            rec_d.timestamp = frame_t_q - trig_time_d;
            seq_d           = seq_q + SEQ_W'(1);
        end
    end

    // State registers.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q        <= st_idle;
            rx_busy_q   <= 1'b0;
            cnt_q       <= '0;
            bitn_q      <= 4'h0;
            shift_q     <= 8'h00;
            low_cnt_q   <= '0;
            idx_q       <= 4'h0;
            sum_q       <= 8'h00;
            id_hit_q    <= 1'b0;
            pair_q      <= 1'b0;
            wrk_q       <= '0;
            rec_q       <= '0;
            rec_valid_q <= 1'b0;
            trig_q      <= 1'b0;
            time_q      <= '0;
            trig_time_q <= '0;
            frame_t_q   <= '0;
            seq_q       <= '0;
        end else begin
            st_q        <= st_d;
            rx_busy_q   <= rx_busy_d;
            cnt_q       <= cnt_d;
            bitn_q      <= bitn_d;
            shift_q     <= shift_d;
            low_cnt_q   <= low_cnt_d;
            idx_q       <= idx_d;
            sum_q       <= sum_d;
            id_hit_q    <= id_hit_d;
            pair_q      <= pair_d;
            wrk_q       <= wrk_d;
            rec_q       <= rec_d;
            rec_valid_q <= rec_valid_d;
            trig_q      <= trig_d;
            time_q      <= time_q + TS_W'(1);
            trig_time_q <= trig_time_d;
            frame_t_q   <= frame_t_d;
            seq_q       <= seq_d;
        end
    end

    // Checks on the trigger, the parser and the records.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    break_trig_a: assert property (trig_q && cfg.mode == lbtd_break_mode |-> $past(rise) && $past(low_cnt_q) >= CNT_W'(BREAK_BITS) * CNT_W'(bitc)) else $error("break trigger without long low");
    id_trig_a: assert property (trig_q && cfg.mode == lbtd_identifier_mode |-> $past(st_q == st_pid && byte_done && shift_q[5:0] == cfg.match_id)) else $error("identifier trigger misplaced");
    serial_gate_a: assert property (trig_q |-> $past(cfg.serial_sel)) else $error("trigger without serial select");
    id_first_a: assert property (trig_q && cfg.mode == identifier_and_payload_match_mode |-> $past(id_hit_q && st_q == st_data)) else $error("data trigger without identifier");
    pair_order_a: assert property (trig_q && cfg.mode == identifier_and_payload_match_mode && cfg.first_data_care && cfg.second_data_care |-> $past(pair_q && shift_q == cfg.second_data_match_value)) else $error("pair order broken");
    any_byte_a: assert property (cfg.serial_sel && cfg.mode == identifier_and_payload_match_mode && !cfg.first_data_care && !cfg.second_data_care && st_q == st_data && byte_done && stop_ok && id_hit_q |=> trig_q) else $error("don't-care byte missed");
    single_val_a: assert property (cfg.serial_sel && cfg.mode == identifier_and_payload_match_mode && cfg.first_data_care && !cfg.second_data_care && st_q == st_data && byte_done && stop_ok && id_hit_q && shift_q == cfg.first_data_match_value |=> trig_q) else $error("single value missed");
    err_trig_a: assert property (cfg.serial_sel && cfg.mode == lbtd_error_mode && err_evt |=> trig_q) else $error("error trigger missed");
    sync_check_a: assert property (st_q == st_sync && byte_done && shift_q != SYNC_BYTE |=> st_q == st_idle) else $error("bad sync accepted");
    rec_fields_a: assert property (rec_valid_q |-> rec_q.len == lbtd_data_len(rec_q.pid[5:0]) && rec_q.checksum == $past(shift_q)) else $error("record fields wrong");
    parity_bits_a: assert property (rec_valid_q |-> rec_q.identifier_parity_bits == rec_q.pid[7:6]) else $error("parity bits wrong");
    rec_stamp_a: assert property (rec_valid_q |-> rec_q.timestamp == frame_t_q - trig_time_q && rec_q.seq == seq_q - SEQ_W'(1)) else $error("record stamp wrong");

    break_hit_c: cover property (trig_q && cfg.mode == lbtd_break_mode);
    payload_hit_c: cover property (trig_q && cfg.mode == identifier_and_payload_match_mode);
    csum_err_c: cover property (rec_valid_q && rec_q.err_checksum);
    good_rec_c: cover property (rec_valid_q && !rec_q.err_checksum && !rec_q.err_parity);

endmodule // lbtd_main

// ### lbtd_bit_timer.sv
// Bit time generator: divides the clock rate by the chosen bit rate.
`timescale 1ns/1ps
module lbtd_bit_timer import lbtd_pkg::*; (
    // Clock and reset.
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // Rate selection.
    input  wire logic [2:0]        baud_sel,
    input  wire logic              custom_en,
    input  wire logic [BAUD_W-1:0] custom_baud,
    // Derived timing.
    output logic [DIV_W-1:0]       bit_cycles_q,
    output logic [CNT_W-1:0]       break_cycles_q,
    output logic                   busy_q
);
    localparam logic [DIV_W-1:0] DIVIDEND = DIV_W'(CLK_HZ);

    logic [BAUD_W-1:0] rate;
    logic [BAUD_W-1:0] rate_q;
    logic [BAUD_W-1:0] rate_d;
    logic [BAUD_W:0]   rem_q;
    logic [BAUD_W:0]   rem_d;
    logic [BAUD_W:0]   trial;
    logic [DIV_W-1:0]  quo_q;
    logic [DIV_W-1:0]  quo_d;
    logic [4:0]        step_q;
    logic [4:0]        step_d;
    logic              busy_d;
    logic [DIV_W-1:0]  bitc_d;
    logic [CNT_W-1:0]  brk_d;

    // Restoring divider, one quotient bit per clock; a serial divider is far
    // cheaper than a combinational one and rate changes are rare.
    always_comb begin
        rate   = custom_en ? custom_baud : BAUD_TABLE[baud_sel];
        rate   = (rate == '0) ? BAUD_W'(1) : rate;
        rate_d = rate_q;
        rem_d  = rem_q;
        quo_d  = quo_q;
        step_d = step_q;
        busy_d = busy_q;
        bitc_d = bit_cycles_q;
        brk_d  = break_cycles_q;
        trial  = {rem_q[BAUD_W-1:0], DIVIDEND[step_q]};
        if (busy_q) begin
            rem_d  = (trial >= {1'b0, rate_q}) ? trial - {1'b0, rate_q} : trial;
            quo_d  = {quo_q[DIV_W-2:0], (trial >= {1'b0, rate_q})};
            step_d = step_q - 5'h01;
            if (step_q == 5'h00) begin
                busy_d = 1'b0;
                bitc_d = quo_d;
                brk_d  = CNT_W'(quo_d) * CNT_W'(BREAK_BITS);
            end
        end else if (rate != rate_q) begin
            rate_d = rate;
            rem_d  = '0;
            quo_d  = '0;
            step_d = 5'(DIV_W - 1);
            busy_d = 1'b1;
        end
    end

    // Rate zero at reset forces a division after release.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rate_q         <= '0;
            rem_q          <= '0;
            quo_q          <= '0;
            step_q         <= 5'h00;
            busy_q         <= 1'b0;
            bit_cycles_q   <= DIV_W'(1);
            break_cycles_q <= '1;
        end else begin
            rate_q         <= rate_d;
            rem_q          <= rem_d;
            quo_q          <= quo_d;
            step_q         <= step_d;
            busy_q         <= busy_d && (rate_d != '0);
            bit_cycles_q   <= bitc_d;
            break_cycles_q <= brk_d;
        end
    end

    rate_div_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(busy_q) |-> bit_cycles_q == DIV_W'(CLK_HZ / rate_q)) else $error("bit time wrong");
    break_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(busy_q) |-> break_cycles_q == CNT_W'(bit_cycles_q) * CNT_W'(BREAK_BITS)) else $error("break length wrong");

endmodule // lbtd_bit_timer

// ### lbtd_lin_node.sv
// LIN master model that drives the sampled bus voltage seen by the monitor.
`timescale 1ns/1ps
module lbtd_lin_node (
    // Clock and bus voltage code.
    input  wire logic        sys_clk,
    output logic      [11:0] adc_sample
);
    // Last sent identifier byte and checksum, kept for the bench.
    logic [7:0] pid_x;
    logic [7:0] csum_x;
    logic [8:0] s;
    // The bus idles recessive, well above the bench threshold.
    initial adc_sample = 12'hc00;
    // One bit lasts 100 clocks at the bench bit rate.
    task automatic send_bit(input logic b);
        repeat (100) @(posedge sys_clk) adc_sample <= b ? 12'hc00 : 12'h100;
    endtask
    // Start bit, eight bits least significant first, stop bit.
    task automatic send_byte(input logic [7:0] v);
        send_bit(1'b0);
        for (int i = 0; i < 8; i++) send_bit(v[i]);
        send_bit(1'b1);
    endtask
    // Break, sync, identifier, two data bytes and checksum; bad inverts the checksum.
    task automatic send_frame(input logic [5:0] id, input logic [15:0] d, input logic bad);
        pid_x = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
        s = {1'b0, pid_x} + {1'b0, d[7:0]};
        s = {1'b0, s[7:0]} + {8'h00, s[8]};
        s = {1'b0, s[7:0]} + {1'b0, d[15:8]};
        s = {1'b0, s[7:0]} + {8'h00, s[8]};
        csum_x = ~s[7:0] ^ {8{bad}};
        repeat (14) send_bit(1'b0);
        send_bit(1'b1);
        send_byte(8'h55);
        send_byte(pid_x);
        send_byte(d[7:0]);
        send_byte(d[15:8]);
        send_byte(csum_x);
        send_bit(1'b1);
    endtask
endmodule // lbtd_lin_node

// ### test_lbtd_main.sv
// Self-checking bench of the LIN trigger decoder.
`timescale 1ns/1ps
module test_lbtd_main import lbtd_pkg::*; ;
    `define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
        $display("wrong value at %0t: %h expected %h", $time, a, e); end end
    logic       sys_clk = 1'b0;
    logic       nrst    = 1'b0;
    logic [11:0] adc_sample;
    lbtd_cfg_t  cfg;
    logic       trig_q;
    logic       rec_valid_q;
    lbtd_rec_t  rec_q;
    lbtd_rec_t  got;
    logic [15:0] seq_x = 16'h0000;
    int err_total = 0, check_count = 0, trig_n = 0, rec_n = 0;
    // Clock of 10 ns.
    initial forever #5 sys_clk = ~sys_clk;
    // Pulses are counted and records caught, as each stands a single cycle.
    always @(posedge sys_clk) begin
        if (trig_q === 1'b1) trig_n <= trig_n + 1;
        if (rec_valid_q === 1'b1) begin
            rec_n <= rec_n + 1;
            got   <= rec_q;
        end
    end
    lbtd_lin_node u_node (.sys_clk(sys_clk), .adc_sample(adc_sample));
    lbtd_main u_dut (.sys_clk(sys_clk), .nrst(nrst), .adc_sample(adc_sample), .cfg(cfg),
                     .trig_q(trig_q), .rec_valid_q(rec_valid_q), .rec_q(rec_q));
    // Verdict and end of run.
    task automatic final_report();
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One frame under one trigger setup, then its trigger count and record are judged.
    task automatic run(input lbtd_mode_t m, input logic sel, input logic [5:0] id, input logic [1:0] c,
                       input logic [15:0] d, input logic bad, input int ex);
        int t0, r0;
        @(posedge sys_clk);
        cfg.mode             <= m;
        cfg.serial_sel       <= sel;
        cfg.first_data_care  <= c[1];
        cfg.second_data_care <= c[0];
        t0 = trig_n;
        r0 = rec_n;
        u_node.send_frame(id, d, bad);
        `CHK(trig_n - t0, ex)
        `CHK(rec_n - r0, 1)
        `CHK(got.pid, u_node.pid_x)
        `CHK(got.identifier_parity_bits, u_node.pid_x[7:6])
        `CHK({got.len, got.data[1], got.data[0], got.checksum}, {4'h2, d, u_node.csum_x})
        `CHK(got.err_checksum, bad)
        `CHK(got.err_parity, 1'b0)
        // A break trigger and its frame share one instant, so the offset is zero.
        if (m == lbtd_break_mode && sel) `CHK(got.timestamp, 32'h0)
        `CHK(got.seq, seq_x)
        seq_x = seq_x + 16'h0001;
    endtask
    // A hang is cut short at 90000 clocks, well beyond the longest sequence.
    initial begin
        #900000;
        err_total++;
        final_report();
    end
    // Reset, fast custom rate of 100 clocks a bit, then the trigger scenarios.
    initial begin
        cfg = '0;
        cfg.custom_en = 1'b1;
        cfg.custom_baud = 20'hf4240;
        cfg.threshold = 12'h800;
        cfg.match_id = 6'h05;
        cfg.first_data_match_value = 8'h11;
        cfg.second_data_match_value = 8'h22;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (40) @(posedge sys_clk);
        run(lbtd_break_mode, 1'b1, 6'h05, 2'h3, 16'h2211, 1'b0, 1);
        run(lbtd_break_mode, 1'b0, 6'h05, 2'h3, 16'h2211, 1'b0, 0);
        run(lbtd_identifier_mode, 1'b1, 6'h05, 2'h3, 16'h2211, 1'b0, 1);
        run(lbtd_identifier_mode, 1'b1, 6'h16, 2'h3, 16'h2211, 1'b0, 0);
        run(identifier_and_payload_match_mode, 1'b1, 6'h05, 2'h3, 16'h2211, 1'b0, 1);
        run(identifier_and_payload_match_mode, 1'b1, 6'h05, 2'h3, 16'h1122, 1'b0, 0);
        run(identifier_and_payload_match_mode, 1'b1, 6'h05, 2'h1, 16'h3322, 1'b0, 1);
        run(identifier_and_payload_match_mode, 1'b1, 6'h06, 2'h3, 16'h2211, 1'b0, 0);
        run(lbtd_error_mode, 1'b1, 6'h05, 2'h3, 16'h2211, 1'b1, 1);
        run(lbtd_error_mode, 1'b1, 6'h05, 2'h3, 16'h2211, 1'b0, 0);
        run(identifier_and_payload_match_mode, 1'b1, 6'h05, 2'h0, 16'h3322, 1'b0, 2);
        // Switch to the fastest predefined rate; the division settles within 30 clocks.
        cfg.custom_en <= 1'b0;
        cfg.baud_sel  <= 3'h7;
        repeat (40) @(posedge sys_clk);
        `CHK(u_dut.bitc, CLK_HZ / BAUD_TABLE[7])
        final_report();
    end
endmodule // test_lbtd_main
